/* bench/rfef_event_flags_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rfef_event_flags_bench
  import rfef_pkg::*;
;
  // ------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [13:0] ev = 14'h0000;
  logic zlen = 1'b0, autor = 1'b0, abdis = 1'b0, cnten = 1'b0, dbuf = 1'b0;
  logic [31:0] mask = 32'h00000000;
  logic [15:0] crc_c = 16'h0000, crc_r = 16'h0000;
  logic [RFEF_TS_W-1:0] raw = 40'h0000000000;
  logic [RFEF_ADLY_W-1:0] dly = 16'h0000;
  logic reg_wr, irq, ts_err, abrt, rst_rx;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, st;
  logic [RFEF_TS_W-1:0] ts;
  logic [RFEF_CNT_W-1:0] hcnt, ccnt;
  int n_fail = 0, comparisons = 0, n_abort = 0, n_rst = 0;
  always #5 clk_sys = ~clk_sys;
  // Abort pulses are counted rather than timed to an exact edge
  always @(posedge clk_sys) begin
    if (abrt === 1'b1) n_abort++;
    if (rst_rx === 1'b1) n_rst++;
  end
  rfef_event_flags rfef_event_flags_i (.clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(st), .event_mask(mask), .irq(irq), .tx_enable(ev[0]),
    .tx_preamble_end(ev[1]), .tx_header_done(ev[2]), .tx_zero_length(zlen), .tx_payload_done(ev[3]),
    .rx_enable(ev[4]), .rx_auto_reenable(autor), .header_error_abort_disable(abdis),
    .event_count_enable(cnten), .double_buffer_enable(dbuf), .buffer_swap(ev[13]),
    .rx_preamble_confirmed(ev[5]), .rx_delimiter_found(ev[6]), .rx_header_done(ev[7]),
    .rx_header_single_err(ev[8]), .rx_header_double_err(ev[9]), .rx_frame_end(ev[10]),
    .rx_crc_computed(crc_c), .rx_crc_received(crc_r), .leading_edge_search_done(ev[11]),
    .leading_edge_search_fail(ev[12]), .rx_arrival_raw(raw), .rx_antenna_delay(dly), .rx_timestamp(ts),
    .timestamp_adjust_error(ts_err), .rx_abort(abrt), .rx_restart(rst_rx), .header_error_count(hcnt),
    .crc_error_count(ccnt));
  rfef_host_model rfef_host_model_i (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  // ------------------------------------------
  // Shared helpers
  // ------------------------------------------
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One-cycle event pulse; returns just after the edge that takes it
  task automatic pulse(input int i);
    @(posedge clk_sys);
    ev[i] <= 1'b1;
    @(posedge clk_sys);
    ev <= 14'h0000;
    #1;
  endtask
  function automatic logic [31:0] b(input int i);
    return 32'h00000001 << i;
  endfunction
  // Bounded wait for frame ready
  task automatic wait_ready();
    for (int k = 0; k < 4 && st[13] !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_tx();
    pulse(0);
    pulse(1);
    chk("tx pre", b(5), st);
    pulse(2);
    chk("tx hdr", b(5) | b(6), st);
    pulse(3);
    chk("tx frm", 32'h000000E0, st);
    rfef_host_model_i.wr(8'h0F, 32'hFFFF001F);
    rfef_host_model_i.wr(8'h0E, 32'hFFFFFFFF);
    chk("w0 keep", 32'h000000E0, st);
    rfef_host_model_i.wr(8'h0F, b(6));
    chk("w1 clr", 32'h000000A0, st);
    pulse(0);
    chk("tx en clr", 32'h00000000, st);
    $display("t_tx done");
  endtask
  task automatic t_zlen();
    zlen <= 1'b1;
    pulse(2);
    chk("zl hdr", b(6), st);
    @(posedge clk_sys);
    #1;
    chk("zl gap", b(6), st);
    @(posedge clk_sys);
    #1;
    chk("zl frm", b(6) | b(7), st);
    zlen <= 1'b0;
    pulse(0);
    $display("t_zlen done");
  endtask
  task automatic t_rx();
    cnten <= 1'b1;
    autor <= 1'b1;
    pulse(4);
    pulse(5);
    chk("rx pre", b(8), st);
    pulse(6);
    pulse(8);
    chk("rx sfd", b(8) | b(9), st);
    pulse(7);
    chk("rx hdr", 32'h00000B00, st);
    pulse(9);
    chk("rx herr", 32'h00001B00, st);
    repeat (3) @(posedge clk_sys);
    chk("abort", 2, n_abort + n_rst);
    chk("herr cnt", 1, hcnt);
    abdis <= 1'b1;
    cnten <= 1'b0;
    pulse(4);
    chk("rx en clr", 0, st);
    pulse(5);
    pulse(9);
    repeat (3) @(posedge clk_sys);
    chk("no abort", 1, n_abort);
    chk("cnt hold", 1, hcnt);
    abdis <= 1'b0;
    pulse(4);
    $display("t_rx done");
  endtask
  task automatic t_frame();
    cnten <= 1'b1;
    mask <= b(13);
    raw <= 40'h0000012345;
    dly <= 16'h0045;
    crc_c <= 16'hBEEF;
    crc_r <= 16'hBEEF;
    pulse(11);
    @(posedge clk_sys);
    #1;
    chk("tstamp", 40'h0000012300, ts);
    chk("ts done", b(10), st);
    chk("irq off", 0, irq);
    pulse(5);
    pulse(10);
    wait_ready();
    chk("crc ok", 32'h00006501, st);
    chk("irq on", 1, irq);
    pulse(4);
    chk("set clr", 0, st);
    crc_r <= 16'hBEEE;
    pulse(5);
    pulse(11);
    pulse(10);
    wait_ready();
    chk("crc bad", 32'h0000A501, st);
    chk("crc cnt", 1, ccnt);
    dbuf <= 1'b1;
    pulse(13);
    chk("swap out", 32'h00000100, st);
    pulse(13);
    chk("swap back", 32'h0000A501, st);
    dbuf <= 1'b0;
    cnten <= 1'b0;
    pulse(4);
    pulse(5);
    pulse(11);
    pulse(10);
    wait_ready();
    chk("cnt off", 1, ccnt);
    mask <= 32'h00000000;
    pulse(12);
    chk("irq mask", 0, irq);
    chk("ts err", 1, ts_err);
    pulse(4);
    chk("err clr", 0, ts_err);
    $display("t_frame done");
  endtask
  task automatic t_race();
    pulse(0);
    fork
      rfef_host_model_i.wr(8'h0F, b(5));
      pulse(1);
    join
    chk("set wins", b(5), st);
    $display("t_race done");
  endtask
  // ------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    chk("reset", RFEF_STATUS_RST, st);
    t_tx();
    t_zlen();
    t_rx();
    t_frame();
    t_race();
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire

/* bench/rfef_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Host side of the status register port
// ------------------------------------------
module rfef_host_model (
  input wire logic clk_sys,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h0F;
    reg_wdata = 32'h00000000;
  end
  // One-cycle strobe; data inverted once released so stale bits never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= 8'h0F;
    reg_wdata <= ~d;
    #1;
  endtask
endmodule
`default_nettype wire

/* hw/rfef_event_flags.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE_01: Set bit 5 at preamble end
// RULE_02: Set bit 6 after header sent
// RULE_03: Set bit 7 when payload done
// RULE_04: Empty frame: bit 7 shortly after 6
// RULE_05: Tx flags clear on tx enable, write-1
// RULE_06: Set bit 8 on confirmed preamble
// RULE_07: Set bit 9 on delimiter found
// RULE_08: Rx flags clear on rx enable, write-1
// RULE_09: Set bit 10 when timestamp adjusted
// RULE_10: Timestamp subtracts receive antenna delay
// RULE_11: Set bit 11 when header decoded
// RULE_12: Bit 12 on double error only
// RULE_13: Header error aborts unless disabled; re-enable
// RULE_14: Count header errors while counting enabled
// RULE_15: Frame ready waits for timestamp result
// RULE_16: CRC good with frame ready on match
// RULE_17: CRC error with frame ready on mismatch
// RULE_18: Count CRC errors while counting enabled
// RULE_19: Rx set swaps buffer, clears on enable
// RULE_20: Host reads CRC, timestamp flags on ready
// RULE_21: Flags latch; write 1 clears, 0 keeps
// RULE_22: Interrupt when any unmasked flag set
// RULE_23: Hardware set beats same-cycle clear
module rfef_event_flags
  import rfef_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] event_mask,
  output logic irq,
  // Transmit milestones
  input wire logic tx_enable,
  input wire logic tx_preamble_end,
  input wire logic tx_header_done,
  input wire logic tx_zero_length,
  input wire logic tx_payload_done,
  // Receive milestones
  input wire logic rx_enable,
  input wire logic rx_auto_reenable,
  input wire logic header_error_abort_disable,
  input wire logic event_count_enable,
  input wire logic double_buffer_enable,
  input wire logic buffer_swap,
  input wire logic rx_preamble_confirmed,
  input wire logic rx_delimiter_found,
  input wire logic rx_header_done,
  input wire logic rx_header_single_err,
  input wire logic rx_header_double_err,
  input wire logic rx_frame_end,
  input wire logic [15:0] rx_crc_computed,
  input wire logic [15:0] rx_crc_received,
  input wire logic leading_edge_search_done,
  input wire logic leading_edge_search_fail,
  input wire logic [RFEF_TS_W-1:0] rx_arrival_raw,
  input wire logic [RFEF_ADLY_W-1:0] rx_antenna_delay,
  output logic [RFEF_TS_W-1:0] rx_timestamp,
  output logic timestamp_adjust_error,
  output logic rx_abort,
  output logic rx_restart,
  output logic [RFEF_CNT_W-1:0] header_error_count,
  output logic [RFEF_CNT_W-1:0] crc_error_count
);

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  wire status_hit = reg_wr && (reg_addr == RFEF_STATUS_OFS);
  wire [RFEF_NFLAG-1:0] wr_clear = status_hit ? reg_wdata[RFEF_FLAG_HI:RFEF_FLAG_LO] : '0;

  // ----------------------------------------------------------------
  // Receive sequencing
  // ----------------------------------------------------------------
  rfef_rx_e rx_state_q, rx_state_d;
  logic crc_match_q, crc_match_d;
  logic ts_done_q;
  logic ts_err_q;

  wire header_fatal = rx_header_double_err && !header_error_abort_disable; // RULE_13
  wire ts_finished = ts_done_q || ts_err_q;
  wire crc_equal = (rx_crc_computed == rx_crc_received);

  // Frame end parks until the timestamp result is known
  always_comb begin
    rx_state_d = rx_state_q;
    crc_match_d = crc_match_q;
    unique case (rx_state_q)
      RFEF_RX_IDLE: begin
        if (rx_preamble_confirmed) begin
          rx_state_d = RFEF_RX_FRAME;
        end
      end
      RFEF_RX_FRAME: begin
        if (header_fatal) begin
          rx_state_d = RFEF_RX_ABORT; // RULE_13
        end else if (rx_frame_end) begin
          crc_match_d = crc_equal;
          rx_state_d = RFEF_RX_WAIT_TS; // RULE_15
        end
      end
      RFEF_RX_WAIT_TS: begin
        if (ts_finished) begin
          rx_state_d = RFEF_RX_IDLE;
        end
      end
      RFEF_RX_ABORT: begin
        rx_state_d = RFEF_RX_IDLE;
      end
    endcase
    if (rx_enable) begin
      rx_state_d = RFEF_RX_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_state_q <= RFEF_RX_IDLE;
      crc_match_q <= 1'b0;
    end else begin
      rx_state_q <= rx_state_d;
      crc_match_q <= crc_match_d;
    end
  end

  wire frame_ready_ev = (rx_state_q == RFEF_RX_WAIT_TS) && ts_finished; // RULE_15
  assign rx_abort = (rx_state_q == RFEF_RX_ABORT);
  assign rx_restart = rx_abort && rx_auto_reenable; // RULE_13

  // ----------------------------------------------------------------
  // Timestamp adjustment
  // ----------------------------------------------------------------
  // Error output is kept separate; it has no status bit of its own
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_timestamp <= RFEF_TS_RST;
      ts_err_q <= 1'b0;
    end else begin
      if (leading_edge_search_done) begin
        rx_timestamp <= rx_arrival_raw - {{(RFEF_TS_W-RFEF_ADLY_W){1'b0}}, rx_antenna_delay}; // RULE_10
      end
      if (rx_enable) begin
        ts_err_q <= 1'b0;
      end else if (leading_edge_search_fail) begin
        ts_err_q <= 1'b1;
      end
    end
  end
  assign timestamp_adjust_error = ts_err_q;

  // ----------------------------------------------------------------
  // Zero-length transmit delay
  // ----------------------------------------------------------------
  logic [1:0] zlen_cnt_q;
  wire zlen_fire = (zlen_cnt_q == 2'h1);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      zlen_cnt_q <= 2'h0;
    end else if (tx_enable) begin
      zlen_cnt_q <= 2'h0;
    end else if (tx_header_done && tx_zero_length) begin
      zlen_cnt_q <= RFEF_ZLEN_GAP; // RULE_04
    end else if (zlen_cnt_q != 2'h0) begin
      zlen_cnt_q <= zlen_cnt_q - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Flag set and auto-clear vectors
  // ----------------------------------------------------------------
  // Single-bit header errors are corrected and raise nothing
  wire hdr_err_ev = rx_header_double_err && (rx_state_q == RFEF_RX_FRAME); // RULE_12
  wire [RFEF_NFLAG-1:0] set_vec = {
    frame_ready_ev && !crc_match_q, // RULE_17
    frame_ready_ev && crc_match_q, // RULE_16
    frame_ready_ev, // RULE_15
    hdr_err_ev, // RULE_12
    rx_header_done, // RULE_11
    leading_edge_search_done, // RULE_09
    rx_delimiter_found, // RULE_07
    rx_preamble_confirmed, // RULE_06
    tx_payload_done || zlen_fire, // RULE_03 RULE_04
    tx_header_done, // RULE_02
    tx_preamble_end // RULE_01
  };
  wire [RFEF_NFLAG-1:0] auto_clr = {{8{rx_enable}}, {3{tx_enable}}}; // RULE_05 RULE_08 RULE_19

  // ----------------------------------------------------------------
  // Latched flags, one per bit
  // ----------------------------------------------------------------
  // Two flag banks; the four-flag receive set follows the active buffer
  logic [RFEF_NFLAG-1:0] flags_q;
  logic [3:0] shadow_q;
  logic bank_q;
  wire swap = double_buffer_enable && buffer_swap && !frame_ready_ev;

  genvar gi;
  generate
    for (gi = 0; gi < RFEF_NFLAG; gi++) begin : g_flag
      // Index kept in range for every bit, not only the swinging four
      localparam bit IN_SET = (gi == 5) || (gi >= 8);
      localparam int SH_IDX = (gi == 5) ? 0 : ((gi >= 8) ? gi - 7 : 0);
      wire clr = wr_clear[gi] || auto_clr[gi];
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          flags_q[gi] <= 1'b0;
        end else if (set_vec[gi]) begin
          flags_q[gi] <= 1'b1; // RULE_21 RULE_23
        end else if (IN_SET && swap) begin
          flags_q[gi] <= shadow_q[SH_IDX]; // RULE_19
        end else if (clr) begin
          flags_q[gi] <= 1'b0; // RULE_05 RULE_08
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shadow_q <= 4'h0;
      bank_q <= 1'b0;
    end else if (rx_enable) begin
      shadow_q <= 4'h0; // RULE_19
    end else if (swap) begin
      shadow_q <= {flags_q[10:8], flags_q[5]};
      bank_q <= ~bank_q;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ts_done_q <= 1'b0;
    end else begin
      ts_done_q <= flags_q[5] || leading_edge_search_done;
    end
  end

  // ----------------------------------------------------------------
  // Event counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      header_error_count <= RFEF_CNT_RST;
      crc_error_count <= RFEF_CNT_RST;
    end else begin
      if (hdr_err_ev && event_count_enable) begin
        header_error_count <= header_error_count + 12'h001; // RULE_14
      end
      if (set_vec[10] && event_count_enable) begin
        crc_error_count <= crc_error_count + 12'h001; // RULE_18
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and interrupt
  // ----------------------------------------------------------------
  wire [31:0] status_word = {16'h0000, flags_q, 5'h00};
  wire any_pending = |(status_word & event_mask); // RULE_22
  assign irq = any_pending;
  assign reg_rdata = (reg_addr == RFEF_STATUS_OFS) ? {status_word[31:1], any_pending} : 32'h00000000;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wire unused_ok = rx_header_single_err ^ bank_q;

  flag_set_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_23
    tx_preamble_end |=> flags_q[0]) else $error("preamble flag not set");
  write0_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_21
    flags_q[2] && status_hit && !reg_wdata[7] && !tx_enable |=> flags_q[2]) else $error("write 0 cleared flag");
  tx_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_05
    tx_enable && !tx_header_done |=> !flags_q[1]) else $error("tx enable did not clear");
  zero_len_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_04
    tx_header_done && tx_zero_length && !tx_enable ##1 !tx_enable [*2] |=> flags_q[2]) else $error("empty frame flag late");
  ready_wait_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_15
    $rose(flags_q[8]) && !$past(swap) |-> $past(ts_finished)) else $error("frame ready before timestamp");
  crc_pair_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_16
    frame_ready_ev |=> flags_q[9] != flags_q[10] || swap) else $error("crc flags not exclusive");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_22
    irq == |(status_word & event_mask)) else $error("irq mismatch");
  hdr_count_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_14
    !event_count_enable |=> $stable(header_error_count)) else $error("counter moved while disabled");

  // ----------------------------------------------------------------
  // Per-event checks
  // ----------------------------------------------------------------
  // Transmit milestones land one edge after their pulse
  hdr_sent_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_02
    tx_header_done |=> flags_q[1]) else $error("header sent flag not set");
  frame_sent_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_03
    tx_payload_done |=> flags_q[2]) else $error("frame sent flag not set");

  // Receive milestones land one edge after their pulse
  pre_det_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_06
    rx_preamble_confirmed |=> flags_q[3]) else $error("preamble detect flag not set");
  sfd_det_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_07
    rx_delimiter_found |=> flags_q[4]) else $error("delimiter flag not set");
  hdr_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_11
    rx_header_done |=> flags_q[6]) else $error("header decoded flag not set");

  // Timestamp result and its flag appear together
  ts_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_09
    leading_edge_search_done |=> flags_q[5]) else $error("timestamp done flag not set");
  ts_adjust_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_10
    leading_edge_search_done |=> rx_timestamp == $past(rx_arrival_raw) - {24'h000000, $past(rx_antenna_delay)})
    else $error("timestamp not adjusted");

  // Corrected single errors must stay silent
  hdr_single_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_12
    rx_header_single_err && !rx_header_double_err && !flags_q[7] |=> !flags_q[7])
    else $error("single header error flagged");

  // Abort only when the disable bit is clear
  abort_go_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_13
    header_fatal && rx_state_q == RFEF_RX_FRAME && !rx_enable |=> rx_abort) else $error("no abort on header error");
  abort_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_13
    rx_header_double_err && header_error_abort_disable && rx_state_q == RFEF_RX_FRAME && !rx_enable |=> !rx_abort)
    else $error("abort while disabled");
  hdr_inc_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_14
    hdr_err_ev && event_count_enable |=> header_error_count == $past(header_error_count) + 12'h001)
    else $error("header error not counted");

  // Frame ready carries exactly the matching CRC flag
  crc_good_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_16
    frame_ready_ev && crc_match_q |=> flags_q[9]) else $error("crc good not set");
  crc_bad_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_17
    frame_ready_ev && !crc_match_q |=> flags_q[10]) else $error("crc error not set");
  crc_inc_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_18
    frame_ready_ev && !crc_match_q && event_count_enable |=> crc_error_count == $past(crc_error_count) + 12'h001)
    else $error("crc error not counted");

  // Enables and write-1 clear; a same-cycle set still wins
  rx_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_08
    rx_enable && !rx_preamble_confirmed |=> !flags_q[3]) else $error("rx enable did not clear");
  set_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_19
    rx_enable && !frame_ready_ev && !swap |=> !flags_q[8]) else $error("rx enable kept frame ready");
  wr1_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_21
    status_hit && reg_wdata[5] && !tx_preamble_end |=> !flags_q[0]) else $error("write 1 did not clear");
  set_wins_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE_23
    status_hit && reg_wdata[6] && tx_header_done |=> flags_q[1]) else $error("clear beat set");

endmodule

`default_nettype wire

/* hw/rfef_pkg.sv */
package rfef_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RFEF_STATUS_OFS = 8'h0F;
  localparam logic [31:0] RFEF_STATUS_RST = 32'h00000000;
  localparam int RFEF_FLAG_LO = 5;
  localparam int RFEF_FLAG_HI = 15;
  localparam int RFEF_NFLAG = 11;

  // ----------------------------------------------------------------
  // Flag positions in the status word
  // ----------------------------------------------------------------
  localparam int BIT_TX_PREAMBLE_SENT = 5;
  localparam int BIT_TX_HEADER_SENT = 6;
  localparam int BIT_TX_FRAME_SENT = 7;
  localparam int BIT_RX_PREAMBLE_DETECTED = 8;
  localparam int BIT_RX_DELIMITER_DETECTED = 9;
  localparam int BIT_TIMESTAMP_ADJUST_DONE = 10;
  localparam int BIT_RX_HEADER_DECODED = 11;
  localparam int BIT_RX_HEADER_ERROR = 12;
  localparam int BIT_RX_FRAME_READY = 13;
  localparam int BIT_RX_CRC_GOOD = 14;
  localparam int BIT_RX_CRC_ERROR = 15;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int RFEF_TS_W = 40;
  localparam int RFEF_ADLY_W = 16;
  localparam int RFEF_CNT_W = 12;
  localparam logic [RFEF_CNT_W-1:0] RFEF_CNT_RST = 12'h000;
  localparam logic [RFEF_TS_W-1:0] RFEF_TS_RST = 40'h0000000000;
  // Cycles from header-sent to frame-sent on an empty payload
  localparam logic [1:0] RFEF_ZLEN_GAP = 2'h2;

  typedef enum logic [3:0] {
    RFEF_RX_IDLE = 4'b0001,
    RFEF_RX_FRAME = 4'b0010,
    RFEF_RX_WAIT_TS = 4'b0100,
    RFEF_RX_ABORT = 4'b1000
  } rfef_rx_e;

endpackage
